// >>> hw/eeprom_config_autoload.sv
`timescale 1ns/1ps
// Function
// - Station address comes from words zero to two, bytes zero to five.
// - Load-control bits 1:0 equal 01 replace vendor and product identities.
// - Load-control bits 3:2 equal 01 apply pin-control bits 4:0.
// - Load-control bits 7:6 equal 01 apply option bits 3:1 in 8-bit mode.
// - Codes in 11:10, 13:12, 15:14 enable option bit 7, 8, 15:12.
// - Vendor identity is read from word four, bytes eight and nine.
// - Product identity is read from word five, bytes ten and eleven.
// - Pin-control word sets pin polarities only when load-control bits 3:2 are 01.
// - Pin-control bit 0 makes chip select active low, also the default.
// - Bits 1 and 2 make read and write strobes active low, default.
// - Bit 3 makes interrupt active low; default is active high.
// - Bit 4 makes interrupt open collector; default drives both levels.
// - Option bit 1 selects pulse wake output instead of level.
// - Option bit 2 enables magic-packet wake, default off.
// - Option bit 3 enables link-change wake, default off.
// - Option bit 7 selects LED mode one; default mode zero.
// - Option bit 8 enables internal PHY after power-on; default off.
module eeprom_config_autoload #(
  parameter logic [15:0] vendor_default  = 16'h1234, // Arbitrary value.
  parameter logic [15:0] product_default = 16'h5678  // Arbitrary value.
) (
  input  wire logic                    clock,          // System clock.
  input  wire logic                    arst_n,         // Async reset.
  input  wire logic                    mode_8bit,      // Host bus is 8-bit.
  output logic                         rom_req,        // Word read request.
  output logic [3:0]                   rom_addr,       // Word address.
  input  wire logic                    rom_valid,      // Word data valid.
  input  wire logic [15:0]             rom_data,       // Word data.
  output logic [47:0]                  station_addr,   // Physical address.
  output logic [15:0]                  vendor_id,      // Vendor identity.
  output logic [15:0]                  product_id,     // Product identity.
  output cfg_load_pkg::config_s        cfg,            // Pin and options.
  output logic                         load_done       // Load complete.
);

  cfg_load_pkg::load_state_e state;
  cfg_load_pkg::load_state_e next_state;
  logic [2:0]                 wait_cnt;
  logic [2:0]                 next_wait_cnt;
  logic [15:0]                ctl;
  logic [15:0]                next_ctl;
  logic [3:0]                 next_rom_addr;
  logic                       next_rom_req;
  logic [47:0]                next_station_addr;
  logic [15:0]                next_vendor_id;
  logic [15:0]                next_product_id;
  cfg_load_pkg::config_s      next_cfg;
  logic                       next_load_done;

  function automatic logic accepted(input logic [15:0] w, input int pos);
    accepted = (w[pos +: 2] == cfg_load_pkg::load_code_accept);
  endfunction

  always_comb begin
    next_state        = state;
    next_wait_cnt     = wait_cnt;
    next_ctl          = ctl;
    next_rom_addr     = rom_addr;
    next_rom_req      = 1'b0;
    next_station_addr = station_addr;
    next_vendor_id    = vendor_id;
    next_product_id   = product_id;
    next_cfg          = cfg;
    next_load_done    = load_done;
    case (state)
      cfg_load_pkg::st_wait: begin
        if (wait_cnt == 3'(cfg_load_pkg::start_delay_cycles)) begin
          next_state    = cfg_load_pkg::st_req;
          next_rom_addr = cfg_load_pkg::word_addr0;
        end else begin
          next_wait_cnt = wait_cnt + 3'h1;
        end
      end
      cfg_load_pkg::st_req: begin
        next_rom_req = 1'b1;
        next_state   = cfg_load_pkg::st_data;
      end
      cfg_load_pkg::st_data: begin
        if (rom_valid) begin
          case (rom_addr)
            cfg_load_pkg::word_addr0:
              next_station_addr[15:0]  = rom_data;
            cfg_load_pkg::word_addr1:
              next_station_addr[31:16] = rom_data;
            cfg_load_pkg::word_addr2:
              next_station_addr[47:32] = rom_data;
            cfg_load_pkg::word_load_ctrl: next_ctl = rom_data;
            cfg_load_pkg::word_vendor: begin
              if (accepted(ctl, cfg_load_pkg::ctl_id_pos)) begin
                next_vendor_id = rom_data;
              end
            end
            cfg_load_pkg::word_product: begin
              if (accepted(ctl, cfg_load_pkg::ctl_id_pos)) begin
                next_product_id = rom_data;
              end
            end
            cfg_load_pkg::word_pin_control: begin
              if (accepted(ctl, cfg_load_pkg::ctl_pin_pos)) begin
                next_cfg.cs_active_low  = rom_data[cfg_load_pkg::pin_cs_low];
                next_cfg.rd_active_low  = rom_data[cfg_load_pkg::pin_rd_low];
                next_cfg.wr_active_low  = rom_data[cfg_load_pkg::pin_wr_low];
                next_cfg.int_active_low = rom_data[cfg_load_pkg::pin_int_low];
                next_cfg.int_open_drain = rom_data[cfg_load_pkg::pin_int_od];
              end
            end
            cfg_load_pkg::word_option: begin
              if (accepted(ctl, cfg_load_pkg::ctl_wake_pos)
                  && mode_8bit) begin
                next_cfg.wake_pulse    =
                  rom_data[cfg_load_pkg::opt_wake_pulse];
                next_cfg.magic_wake_en =
                  rom_data[cfg_load_pkg::opt_magic_en];
                next_cfg.link_wake_en  =
                  rom_data[cfg_load_pkg::opt_link_en];
              end
              if (accepted(ctl, cfg_load_pkg::ctl_led_pos)) begin
                next_cfg.led_mode =
                  rom_data[cfg_load_pkg::opt_led_mode];
              end
              if (accepted(ctl, cfg_load_pkg::ctl_phy_pos)) begin
                next_cfg.phy_enable =
                  rom_data[cfg_load_pkg::opt_phy_en];
              end
              if (accepted(ctl, cfg_load_pkg::ctl_high_pos)) begin
                next_cfg.option_high = rom_data[15:12];
              end
            end
            default: begin
            end
          endcase
          if (rom_addr == cfg_load_pkg::word_last) begin
            next_state     = cfg_load_pkg::st_done;
            next_load_done = 1'b1;
          end else begin
            next_rom_addr = rom_addr + 4'h1;
            next_state    = cfg_load_pkg::st_req;
          end
        end
      end
      cfg_load_pkg::st_done: next_state = cfg_load_pkg::st_done;
      default: next_state = cfg_load_pkg::st_wait;
    endcase
  end

  // Fields start at their built-in defaults so unaccepted ones keep them.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state              <= cfg_load_pkg::st_wait;
      wait_cnt           <= 3'h0;
      ctl                <= 16'h0000;
      rom_addr           <= 4'h0;
      rom_req            <= 1'b0;
      station_addr       <= 48'h0;
      vendor_id          <= vendor_default;
      product_id         <= product_default;
      cfg.cs_active_low  <= cfg_load_pkg::pin_control_reset[0];
      cfg.rd_active_low  <= cfg_load_pkg::pin_control_reset[1];
      cfg.wr_active_low  <= cfg_load_pkg::pin_control_reset[2];
      cfg.int_active_low <= cfg_load_pkg::pin_control_reset[3];
      cfg.int_open_drain <= cfg_load_pkg::pin_control_reset[4];
      cfg.wake_pulse     <= cfg_load_pkg::option_reset[1];
      cfg.magic_wake_en  <= cfg_load_pkg::option_reset[2];
      cfg.link_wake_en   <= cfg_load_pkg::option_reset[3];
      cfg.led_mode       <= cfg_load_pkg::option_reset[7];
      cfg.phy_enable     <= cfg_load_pkg::option_reset[8];
      cfg.option_high    <= cfg_load_pkg::option_reset[15:12];
      load_done          <= 1'b0;
    end else begin
      state        <= next_state;
      wait_cnt     <= next_wait_cnt;
      ctl          <= next_ctl;
      rom_addr     <= next_rom_addr;
      rom_req      <= next_rom_req;
      station_addr <= next_station_addr;
      vendor_id    <= next_vendor_id;
      product_id   <= next_product_id;
      cfg          <= next_cfg;
      load_done    <= next_load_done;
    end
  end

  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);

  vendor_gate_a: assert property (
    $changed(vendor_id) |-> $past(accepted(ctl, cfg_load_pkg::ctl_id_pos))
      && $past(rom_addr) == cfg_load_pkg::word_vendor)
    else $error("vendor identity changed without enable");
  product_gate_a: assert property (
    $changed(product_id) |-> $past(rom_addr) == cfg_load_pkg::word_product)
    else $error("product identity loaded from wrong word");
  pin_gate_a: assert property (
    $changed(cfg.int_open_drain) |->
      $past(accepted(ctl, cfg_load_pkg::ctl_pin_pos)))
    else $error("pin polarity changed without enable");
  wake_mode_a: assert property (
    $changed(cfg.magic_wake_en) |-> $past(mode_8bit))
    else $error("wake options applied outside 8-bit mode");
  led_gate_a: assert property (
    $changed(cfg.led_mode) |-> $past(accepted(ctl, cfg_load_pkg::ctl_led_pos)))
    else $error("led mode changed without enable");
  addr_word_a: assert property (
    $changed(station_addr) |-> $past(rom_addr) <= cfg_load_pkg::word_addr2)
    else $error("station address written from wrong word");
  done_hold_a: assert property (
    load_done |=> load_done && !rom_req)
    else $error("loader ran again after completion");
  req_step_a: assert property (
    rom_req |=> !rom_req && $stable(rom_addr))
    else $error("request not a single pulse");
  phy_gate_a: assert property (
    $changed(cfg.phy_enable) |->
      $past(rom_data[cfg_load_pkg::opt_phy_en]) == cfg.phy_enable)
    else $error("phy enable not taken from option bit");

  load_finished_c: cover property (load_done && !$past(load_done));
  vendor_loaded_c: cover property ($changed(vendor_id));
  pin_loaded_c:    cover property ($changed(cfg.int_active_low));
  wake_loaded_c:   cover property ($changed(cfg.magic_wake_en));

endmodule

// >>> hw/cfg_load_pkg.sv
package cfg_load_pkg;

  // Word addresses inside the configuration memory.
  localparam logic [3:0] word_addr0       = 4'h0;
  localparam logic [3:0] word_addr1       = 4'h1;
  localparam logic [3:0] word_addr2       = 4'h2;
  localparam logic [3:0] word_load_ctrl   = 4'h3;
  localparam logic [3:0] word_vendor      = 4'h4;
  localparam logic [3:0] word_product     = 4'h5;
  localparam logic [3:0] word_pin_control = 4'h6;
  localparam logic [3:0] word_option      = 4'h7;
  localparam logic [3:0] word_last        = 4'h7;

  // Enable code held in each two-bit field of the load-control word.
  localparam logic [1:0] load_code_accept = 2'h1;

  // Load-control field positions (low bit of each pair).
  localparam int ctl_id_pos     = 0;
  localparam int ctl_pin_pos    = 2;
  localparam int ctl_wake_pos   = 6;
  localparam int ctl_led_pos    = 10;
  localparam int ctl_phy_pos    = 12;
  localparam int ctl_high_pos   = 14;

  // Pin-control and option word field positions.
  localparam int pin_cs_low     = 0;
  localparam int pin_rd_low     = 1;
  localparam int pin_wr_low     = 2;
  localparam int pin_int_low    = 3;
  localparam int pin_int_od     = 4;
  localparam int opt_wake_pulse = 1;
  localparam int opt_magic_en   = 2;
  localparam int opt_link_en    = 3;
  localparam int opt_led_mode   = 7;
  localparam int opt_phy_en     = 8;

  // Built-in defaults used when a field is not accepted.
  // Strobes and chip select default active low; interrupt active high, driven.
  localparam logic [8:0]  pin_control_reset = 9'h007;
  localparam logic [15:0] option_reset      = 16'h0000;

  // Wait after reset before the first word request, as a time and in cycles.
  localparam int start_delay_ns     = 20;
  localparam int clock_period_ns    = 4;
  localparam int start_delay_cycles =
    (start_delay_ns + clock_period_ns - 1) / clock_period_ns;

  typedef struct packed {
    logic        cs_active_low;
    logic        rd_active_low;
    logic        wr_active_low;
    logic        int_active_low;
    logic        int_open_drain;
    logic        wake_pulse;
    logic        magic_wake_en;
    logic        link_wake_en;
    logic        led_mode;
    logic        phy_enable;
    logic [3:0]  option_high;
  } config_s;

  typedef enum logic [2:0] {
    st_wait  = 3'b000,
    st_req   = 3'b001,
    st_data  = 3'b011,
    st_done  = 3'b010
  } load_state_e;

endpackage

// >>> sim/rom_model.sv
`timescale 1ns/1ps
module rom_model (
  input  wire logic        clock,     // System clock.
  input  wire logic        arst_n,    // Async reset.
  input  wire logic        rom_req,   // Word read request.
  input  wire logic [3:0]  rom_addr,  // Word address.
  output logic             rom_valid, // Word data valid.
  output logic [15:0]      rom_data   // Word data.
);
  logic [15:0] mem [8];
  int          delay;
  int          n_req;
  int          n_bad;

  initial begin
    rom_valid = 1'b0;
    rom_data  = 16'h0000;
    delay     = 0;
    n_req     = 0;
    n_bad     = 0;
  end

  // Outside the valid cycle the data bus shows the inverse of the last
  // word, so a loader that samples late cannot pick up the word by luck.
  always @(posedge clock) begin
    if (arst_n && rom_req) begin
      if (rom_addr !== n_req[3:0])
        n_bad++;
      n_req++;
      repeat (delay) @(posedge clock);
      #1;
      rom_valid = 1'b1;
      rom_data  = mem[rom_addr];
      @(posedge clock);
      #1;
      rom_valid = 1'b0;
      rom_data  = ~rom_data;
    end
  end
endmodule

// >>> sim/eeprom_config_autoload_tb.sv
`timescale 1ns/1ps
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin \
  n_mismatch++; $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp); \
  end end
module eeprom_config_autoload_tb;
  localparam logic [15:0] vid0 = 16'h0bad; // Arbitrary value.
  localparam logic [15:0] pid0 = 16'h0c0d; // Arbitrary value.
  logic                  clock;
  logic                  arst_n;
  logic                  mode_8bit;
  logic                  rom_req;
  logic                  rom_valid;
  logic                  load_done;
  logic [3:0]            rom_addr;
  logic [15:0]           rom_data;
  logic [15:0]           vendor_id;
  logic [15:0]           product_id;
  logic [47:0]           station_addr;
  cfg_load_pkg::config_s cfg;
  int                    n_mismatch = 0;
  int                    total_checks = 0;

  eeprom_config_autoload #(.vendor_default(vid0), .product_default(pid0)) DUT (
    .clock(clock), .arst_n(arst_n), .mode_8bit(mode_8bit),
    .rom_req(rom_req), .rom_addr(rom_addr), .rom_valid(rom_valid),
    .rom_data(rom_data), .station_addr(station_addr),
    .vendor_id(vendor_id), .product_id(product_id), .cfg(cfg),
    .load_done(load_done));

  rom_model u_rom (.clock(clock), .arst_n(arst_n), .rom_req(rom_req),
    .rom_addr(rom_addr), .rom_valid(rom_valid), .rom_data(rom_data));

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  task automatic give_verdict();
    $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  function automatic cfg_load_pkg::config_s exp_cfg(
      logic [15:0] c, logic [15:0] p, logic [15:0] o, logic m8);
    cfg_load_pkg::config_s e;
    e = '0;
    e.cs_active_low = 1'b1;
    e.rd_active_low = 1'b1;
    e.wr_active_low = 1'b1;
    if (c[3:2] == 2'b01) begin
      e.cs_active_low  = p[0];
      e.rd_active_low  = p[1];
      e.wr_active_low  = p[2];
      e.int_active_low = p[3];
      e.int_open_drain = p[4];
    end
    if (c[7:6] == 2'b01 && m8) begin
      e.wake_pulse    = o[1];
      e.magic_wake_en = o[2];
      e.link_wake_en  = o[3];
    end
    if (c[11:10] == 2'b01)
      e.led_mode = o[7];
    if (c[13:12] == 2'b01)
      e.phy_enable = o[8];
    if (c[15:14] == 2'b01)
      e.option_high = o[15:12];
    return e;
  endfunction

  // Entered at a rising edge; resets the loader and checks one full load.
  task automatic run_load(input logic [15:0] ctl, input logic m8,
                          input int dly);
    logic [15:0] p;
    logic [15:0] o;
    int          n;
    p = 16'h0018;
    o = 16'ha18e;
    #1;
    u_rom.mem = '{16'h2211, 16'h4433, 16'h6655, ctl, 16'hbeef, 16'hcafe,
                  p, o};
    u_rom.delay = dly;
    mode_8bit = m8;
    arst_n = 1'b0;
    repeat (12) @(posedge clock);
    u_rom.n_req = 0;
    u_rom.n_bad = 0;
    `CHK(load_done, 1'b0)
    `CHK(cfg, exp_cfg(16'h0000, p, o, m8))
    #1 arst_n = 1'b1;
    n = 0;
    while (load_done !== 1'b1 && n < 300) begin
      @(posedge clock);
      n++;
    end
    `CHK(n < 300, 1'b1)
    #1;
    `CHK(station_addr, 48'h665544332211)
    `CHK(vendor_id, (ctl[1:0] == 2'b01) ? 16'hbeef : vid0)
    `CHK(product_id, (ctl[1:0] == 2'b01) ? 16'hcafe : pid0)
    `CHK(cfg, exp_cfg(ctl, p, o, m8))
    repeat (20) @(posedge clock);
    `CHK(u_rom.n_req, 8)
    `CHK(u_rom.n_bad, 0)
    `CHK(load_done, 1'b1)
  endtask

  // Every field enabled, in both host modes.
  task automatic t_all_fields();
    run_load(16'h5545, 1'b1, 0);
    run_load(16'h5545, 1'b0, 3);
    $display("test all_fields done");
  endtask

  // Each load-control field enabled on its own.
  task automatic t_single_fields();
    for (int i = 0; i < 16; i += 2) begin
      run_load(16'h0001 << i, 1'b1, 1);
    end
    $display("test single_fields done");
  endtask

  // Codes other than 01 leave every field at its default.
  task automatic t_rejected_codes();
    run_load(16'h0000, 1'b1, 0);
    run_load(16'haaaa, 1'b1, 2);
    run_load(16'hffff, 1'b1, 0);
    $display("test rejected_codes done");
  endtask

  // A reset after a load restores defaults; a reset mid-load restarts it.
  // With no wait states word k lands at edge 9 + 3k after release, so at
  // edge 25 the identities are loaded and the last word is still ahead.
  task automatic t_abort();
    run_load(16'h5545, 1'b1, 0);
    #1 arst_n = 1'b0;
    @(posedge clock);
    `CHK(vendor_id, vid0)
    `CHK(load_done, 1'b0)
    #1 arst_n = 1'b1;
    repeat (25) @(posedge clock);
    `CHK(vendor_id, 16'hbeef)
    `CHK(load_done, 1'b0)
    #1 arst_n = 1'b0;
    @(posedge clock);
    `CHK(vendor_id, vid0)
    `CHK(rom_req, 1'b0)
    run_load(16'h5545, 1'b1, 1);
    $display("test abort done");
  endtask

  initial begin
    arst_n = 1'b0;
    mode_8bit = 1'b0;
    t_all_fields();
    t_single_fields();
    t_rejected_codes();
    t_abort();
    give_verdict();
  end

  initial begin
    repeat (20000) @(posedge clock);
    n_mismatch++;
    give_verdict();
  end
endmodule
